// ---- hdl/isr_status_sets.v ----
// Instrument status register sets with transition filters and summaries
`timescale 1ns/10ps
`default_nettype none
`include "isr_map.vh"
module isr_status_sets #(
    parameter WIDTH = 16
) (
    // System clock
    input wire clk,
    // Synchronous reset, active high
    input wire sys_rst,

    // Status sources, all on the system clock
    // Nonvolatile memory has failed
    input wire nvm_failed,
    // Zeroing or calibration run begins
    input wire cal_start,
    // Zeroing or calibration run finished
    input wire cal_done,
    // Measurement in progress
    input wire meas_busy,
    // Measurement completed this cycle
    input wire meas_done,
    // Low limit test enabled
    input wire low_test_en,
    // Low limit comparison failed
    input wire low_test_fail,
    // High limit test enabled
    input wire high_test_en,
    // High limit comparison failed
    input wire high_test_fail,
    // Fetch from nonvolatile storage
    input wire mem_fetch_busy,
    // Entry to waiting for trigger
    input wire trig_enter_wait,
    // Entry to idle
    input wire trig_enter_idle,
    // Power sub-set enabled event OR
    input wire ques_pwr_summary,
    // Calibration sub-set enabled event OR
    input wire ques_cal_summary,
    // Self-test result strobe
    input wire selftest_done,
    // Self-test result, high on failure
    input wire selftest_fail,
    // Status preset action
    input wire status_preset,

    // Register access
    // Write request
    input wire reg_wr,
    // Read request
    input wire reg_rd,
    // Register set selector
    input wire [3:0] reg_set,
    // Register within the set
    input wire [2:0] reg_sel,
    // Write data
    input wire [WIDTH-1:0] reg_wdata,
    // Read data, held until the next read
    output reg [WIDTH-1:0] reg_rdata,
    // Read answer, one cycle
    output reg reg_rvalid
);
    // Register storage, one word per set
    // Condition words as last sampled
    reg [WIDTH-1:0] cond [0:`ISR_SET_COUNT-1];
    // Latched event words
    reg [WIDTH-1:0] event_r [0:`ISR_SET_COUNT-1];
    // Enable masks
    reg [WIDTH-1:0] enable [0:`ISR_SET_COUNT-1];
    // Rising transition filters
    reg [WIDTH-1:0] rise [0:`ISR_SET_COUNT-1];
    // Falling transition filters
    reg [WIDTH-1:0] fall [0:`ISR_SET_COUNT-1];

    // Sticky source state of the calibration, limit and trigger sub-sets and the self-test result
    // Calibration run under way
    reg cal_active;
    // Low limit result memory
    reg low_fail;
    // High limit result memory
    reg high_fail;
    // Waiting for trigger
    reg trig_wait;
    // Self-test failed
    reg post_fail;

    // Next condition values, combinational
    reg [WIDTH-1:0] next_cond [0:`ISR_SET_COUNT-1];

    // Enabled-event OR per set
    wire [`ISR_SET_COUNT-1:0] summary;

    // Access decode
    wire set_ok = (reg_set < `ISR_SET_COUNT);

    // Loop index shared by both generate loops
    genvar g;
    generate
        // One summary bit per set; the six sub-set bits feed the operation word
        for (g = 0; g < `ISR_SET_COUNT; g = g + 1) begin : g_sum
            assign summary[g] = |(event_r[g] & enable[g]);
        end
    endgenerate

    // Sticky status sources
    // Each flag except post_fail is set by a start or failure strobe and cleared by an end strobe; post_fail loads selftest_fail on selftest_done
    always @(posedge clk) begin
        // Reset clears every source
        if (sys_rst) begin
            cal_active <= 1'b0;
            low_fail <= 1'b0;
            high_fail <= 1'b0;
            trig_wait <= 1'b0;
            post_fail <= 1'b0;
        end else begin
            // Normal update, set beats clear
            // Calibrating run flag
            // Set on start
            if (cal_start) begin
                cal_active <= 1'b1;
            end else if (cal_done) begin
                cal_active <= 1'b0;
            end

            // Low limit result memory
            // Low failure sets
            if (low_test_fail) begin
                low_fail <= 1'b1;
            end else if (meas_done && low_test_en) begin
                low_fail <= 1'b0;
            end

            // High limit result memory
            // High failure sets
            if (high_test_fail) begin
                high_fail <= 1'b1;
            end else if (meas_done && high_test_en) begin
                high_fail <= 1'b0;
            end

            // Trigger wait flag
            // Wait sets, idle clears
            if (trig_enter_wait) begin
                trig_wait <= 1'b1;
            end else if (trig_enter_idle) begin
                trig_wait <= 1'b0;
            end

            // Self-test outcome, held between strobes
            // Self-test result
            if (selftest_done) begin
                post_fail <= selftest_fail;
            end
        end
    end

    // Condition composition from sources and summaries
    // Summaries lag their sub-set events by one cycle
    always @* begin : p_cond
        integer i;
        // Clear every word, unused bits stay zero
        for (i = 0; i < `ISR_SET_COUNT; i = i + 1) begin
            next_cond[i] = `ISR_ALL_ZERO;
        end

        next_cond[`ISR_SET_DEV][`ISR_DEV_NVM_BIT] = nvm_failed;
        // Calibrating run flag
        next_cond[`ISR_SET_CAL][`ISR_SUB_STATUS_BIT] = cal_active;
        // Low limit fail memory
        next_cond[`ISR_SET_LLF][`ISR_SUB_STATUS_BIT] = low_fail;
        next_cond[`ISR_SET_MEAS][`ISR_SUB_STATUS_BIT] = meas_busy && !meas_done;
        next_cond[`ISR_SET_MRD][`ISR_SUB_STATUS_BIT] = mem_fetch_busy;
        // Trigger wait flag
        next_cond[`ISR_SET_TRIG][`ISR_SUB_STATUS_BIT] = trig_wait;
        // High limit fail memory
        next_cond[`ISR_SET_HLF][`ISR_SUB_STATUS_BIT] = high_fail;

        next_cond[`ISR_SET_OPER][`ISR_OPER_CAL_BIT] = summary[`ISR_SET_CAL];
        // Measuring summary
        next_cond[`ISR_SET_OPER][`ISR_OPER_MEAS_BIT] = summary[`ISR_SET_MEAS];
        // Trigger wait summary
        next_cond[`ISR_SET_OPER][`ISR_OPER_TRIG_BIT] = summary[`ISR_SET_TRIG];
        // Memory read summary
        next_cond[`ISR_SET_OPER][`ISR_OPER_MRD_BIT] = summary[`ISR_SET_MRD];
        // Low limit fail summary
        next_cond[`ISR_SET_OPER][`ISR_OPER_LLF_BIT] = summary[`ISR_SET_LLF];
        // High limit fail summary
        next_cond[`ISR_SET_OPER][`ISR_OPER_HLF_BIT] = summary[`ISR_SET_HLF];

        next_cond[`ISR_SET_QUES][`ISR_QUES_PWR_BIT] = ques_pwr_summary;
        next_cond[`ISR_SET_QUES][`ISR_QUES_CAL_BIT] = ques_cal_summary;
        next_cond[`ISR_SET_QUES][`ISR_QUES_POST_BIT] = post_fail;
    end

    // Per-set registers: condition, event, enables and filters
    generate
        for (g = 0; g < `ISR_SET_COUNT; g = g + 1) begin : g_set
            // Implemented-bit mask of this set
            wire [WIDTH-1:0] impl_mask = (g == `ISR_SET_DEV) ? `ISR_DEV_MASK :
                                         (g == `ISR_SET_OPER) ? `ISR_OPER_MASK :
                                         (g == `ISR_SET_QUES) ? `ISR_QUES_MASK :
                                         `ISR_SUB_MASK;
            // Transition edges of the condition
            wire [WIDTH-1:0] rising_edges = next_cond[g] & ~cond[g];
            wire [WIDTH-1:0] falling_edges = ~next_cond[g] & cond[g];
            // This set is addressed
            wire hit = set_ok && (reg_set == g);
            // Enable preset value of this set
            wire [WIDTH-1:0] en_preset = ((g == `ISR_SET_OPER) || (g == `ISR_SET_QUES)) ?
                                         `ISR_ALL_ZERO : `ISR_ALL_ONES;

            // Registers of one set
            // Writes in a preset cycle are lost, preset wins
            always @(posedge clk) begin
                // Reset values of every register
                if (sys_rst) begin
                    cond[g] <= `ISR_ALL_ZERO;
                    event_r[g] <= `ISR_ALL_ZERO;
                    enable[g] <= `ISR_ALL_ZERO;
                    rise[g] <= `ISR_ALL_ONES;
                    fall[g] <= `ISR_ALL_ZERO;
                end else begin
                    // Condition, event and filter updates
                    // Unused bits forced zero
                    cond[g] <= next_cond[g] & impl_mask;
                    if (hit && reg_rd && reg_sel == `ISR_REG_EVENT) begin
                        event_r[g] <= (rising_edges & rise[g] | falling_edges & fall[g])
                                      & impl_mask;
                    end else begin
                        event_r[g] <= event_r[g] | ((rising_edges & rise[g] |
                                      falling_edges & fall[g]) & impl_mask);
                    end
                    if (status_preset) begin
                        enable[g] <= en_preset;
                        rise[g] <= `ISR_ALL_ONES;
                        fall[g] <= `ISR_ALL_ZERO;
                    end else if (hit && reg_wr) begin
                        // Software write, condition and event ignore it
                        // Store low 15 bits
                        if (reg_sel == `ISR_REG_ENABLE) begin
                            enable[g] <= reg_wdata & `ISR_WRITE_MASK;
                        end
                        // Rising filter write
                        if (reg_sel == `ISR_REG_RISE) begin
                            rise[g] <= reg_wdata & `ISR_WRITE_MASK;
                        end
                        // Falling filter write
                        if (reg_sel == `ISR_REG_FALL) begin
                            fall[g] <= reg_wdata & `ISR_WRITE_MASK;
                        end
                    end
                end
            end
        end
    endgenerate


    // Read port, one cycle after the request
    // Data holds between reads so software may sample late
    always @(posedge clk) begin
        // Idle outputs in reset
        if (sys_rst) begin
            reg_rdata <= `ISR_ALL_ZERO;
            reg_rvalid <= 1'b0;
        end else begin
            // Answer flag follows the request
            reg_rvalid <= reg_rd;
            // Known set: pick the register
            if (reg_rd && set_ok) begin
                case (reg_sel)
                    `ISR_REG_COND: begin
                        reg_rdata <= cond[reg_set];
                    end
                    // Event read, cleared in the set logic
                    `ISR_REG_EVENT: begin
                        reg_rdata <= event_r[reg_set];
                    end
                    // Enable mask
                    `ISR_REG_ENABLE: begin
                        reg_rdata <= enable[reg_set];
                    end
                    // Rising filter
                    `ISR_REG_RISE: begin
                        reg_rdata <= rise[reg_set];
                    end
                    // Falling filter
                    `ISR_REG_FALL: begin
                        reg_rdata <= fall[reg_set];
                    end
                    // Unused selector reads zero
                    default: begin
                        reg_rdata <= `ISR_ALL_ZERO;
                    end
                endcase
            end else if (reg_rd) begin
                // Unknown set reads zero
                reg_rdata <= `ISR_ALL_ZERO;
            end
        end
    end
endmodule // isr_status_sets
`default_nettype wire

// ---- hdl/isr_map.vh ----
// Register set selectors, field positions and preset values for the status sets
`ifndef ISR_MAP_VH
`define ISR_MAP_VH
// Set selectors
`define ISR_SET_DEV 4'h0
`define ISR_SET_OPER 4'h1
`define ISR_SET_CAL 4'h2
`define ISR_SET_LLF 4'h3
`define ISR_SET_MEAS 4'h4
`define ISR_SET_MRD 4'h5
`define ISR_SET_TRIG 4'h6
`define ISR_SET_HLF 4'h7
`define ISR_SET_QUES 4'h8
`define ISR_SET_COUNT 9
// Register selectors within a set
`define ISR_REG_COND 3'h0
`define ISR_REG_EVENT 3'h1
`define ISR_REG_ENABLE 3'h2
`define ISR_REG_RISE 3'h3
`define ISR_REG_FALL 3'h4
// Field positions
`define ISR_DEV_NVM_BIT 3
`define ISR_SUB_STATUS_BIT 1
`define ISR_OPER_CAL_BIT 0
`define ISR_OPER_MEAS_BIT 4
`define ISR_OPER_TRIG_BIT 5
`define ISR_OPER_MRD_BIT 10
`define ISR_OPER_LLF_BIT 11
`define ISR_OPER_HLF_BIT 12
`define ISR_QUES_PWR_BIT 3
`define ISR_QUES_CAL_BIT 8
`define ISR_QUES_POST_BIT 9
// Masks of implemented bits per set
`define ISR_DEV_MASK 16'h0008
`define ISR_OPER_MASK 16'h1c31
`define ISR_SUB_MASK 16'h0002
`define ISR_QUES_MASK 16'h0308
`define ISR_WRITE_MASK 16'h7fff
// Preset and reset values
`define ISR_ALL_ZERO 16'h0000
`define ISR_ALL_ONES 16'h7fff
`endif

// ---- bench/isr_status_sets_asserts.sv ----
// Port-level checker for the instrument status register sets
`timescale 1ns/10ps
`default_nettype none
`include "isr_map.vh"
module isr_status_sets_asserts #(
    parameter WIDTH = 16
) (
    input wire clk,
    input wire sys_rst,
    input wire nvm_failed,
    input wire selftest_done,
    input wire selftest_fail,
    input wire status_preset,
    input wire reg_wr,
    input wire reg_rd,
    input wire [3:0] reg_set,
    input wire [2:0] reg_sel,
    input wire [WIDTH-1:0] reg_wdata,
    input wire [WIDTH-1:0] reg_rdata,
    input wire reg_rvalid
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Enable write followed at once by a read of the same enable
    sequence s_en_wr_rd;
        reg_wr && reg_sel == 3'h2 && reg_set < 4'h9 && !status_preset
        ##1 reg_rd && !reg_wr && !status_preset && reg_sel == 3'h2 && $stable(reg_set);
    endsequence
    // Two device event reads in a row with no new edge
    sequence s_dev_ev_twice;
        reg_rd && reg_set == 4'h0 && reg_sel == 3'h1 && $stable(nvm_failed) && !$past(sys_rst)
        ##1 reg_rd && reg_set == 4'h0 && reg_sel == 3'h1;
    endsequence
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_no_stray: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    a_top_bit_zero: assert property (reg_rvalid |-> !reg_rdata[15])
        else $error("bit 15 set");
    a_dev_unused: assert property (reg_rd && reg_set == 4'h0 && reg_sel < 3'h2
        |=> (reg_rdata & ~`ISR_DEV_MASK) == 16'h0000) else $error("device unused bit set");
    a_sub_unused: assert property (reg_rd && reg_set > 4'h1 && reg_set < 4'h8 && reg_sel < 3'h2
        |=> (reg_rdata & ~`ISR_SUB_MASK) == 16'h0000) else $error("subset unused bit set");
    a_oper_layout: assert property (reg_rd && reg_set == 4'h1 && reg_sel < 3'h2
        |=> (reg_rdata & ~`ISR_OPER_MASK) == 16'h0000) else $error("operation unused bit set");
    a_dev_nvm: assert property (!$past(sys_rst) && $stable(nvm_failed) && reg_rd
        && reg_set == 4'h0 && reg_sel == 3'h0 |=> reg_rdata[3] == $past(nvm_failed))
        else $error("device memory bit wrong");
    a_enable_keep: assert property (s_en_wr_rd |=>
        reg_rdata == ($past(reg_wdata, 2) & `ISR_WRITE_MASK)) else $error("enable readback");
    a_event_clear: assert property (s_dev_ev_twice |=> reg_rdata == 16'h0000)
        else $error("event not cleared by read");
    a_preset_enable: assert property (status_preset ##1 (reg_rd && reg_sel == 3'h2
        && reg_set < 4'h9) |=> reg_rdata == (($past(reg_set) == 4'h1 || $past(reg_set) == 4'h8)
        ? `ISR_ALL_ZERO : `ISR_ALL_ONES)) else $error("preset enable value");
    a_selftest_bit: assert property (selftest_done ##2 (reg_rd && reg_set == 4'h8
        && reg_sel == 3'h0) |=> reg_rdata[9] == $past(selftest_fail, 3))
        else $error("self-test bit wrong");
endmodule // isr_status_sets_asserts
bind isr_status_sets isr_status_sets_asserts #(.WIDTH(WIDTH)) i_chk (
    .clk(clk), .sys_rst(sys_rst), .nvm_failed(nvm_failed), .selftest_done(selftest_done),
    .selftest_fail(selftest_fail), .status_preset(status_preset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_set(reg_set), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
);
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the instrument status register sets
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic nvm_failed = 1'h0, cal_start = 1'h0, cal_done = 1'h0, meas_busy = 1'h0;
    logic meas_done = 1'h0, low_test_en = 1'h0, low_test_fail = 1'h0, high_test_en = 1'h0;
    logic high_test_fail = 1'h0, mem_fetch_busy = 1'h0, trig_enter_wait = 1'h0;
    logic trig_enter_idle = 1'h0, ques_pwr_summary = 1'h0, ques_cal_summary = 1'h0;
    logic selftest_done = 1'h0, selftest_fail = 1'h0, status_preset = 1'h0;
    logic reg_wr = 1'h0, reg_rd = 1'h0, reg_rvalid;
    logic [3:0] reg_set = 4'h0;
    logic [2:0] reg_sel = 3'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    integer err_count = 0;
    integer comparisons = 0;
    // Free-running system clock
    always #5 clk = ~clk;
    isr_status_sets i_dut (
        .clk(clk), .sys_rst(sys_rst), .nvm_failed(nvm_failed), .cal_start(cal_start),
        .cal_done(cal_done), .meas_busy(meas_busy), .meas_done(meas_done),
        .low_test_en(low_test_en), .low_test_fail(low_test_fail), .high_test_en(high_test_en),
        .high_test_fail(high_test_fail), .mem_fetch_busy(mem_fetch_busy),
        .trig_enter_wait(trig_enter_wait), .trig_enter_idle(trig_enter_idle),
        .ques_pwr_summary(ques_pwr_summary), .ques_cal_summary(ques_cal_summary),
        .selftest_done(selftest_done), .selftest_fail(selftest_fail),
        .status_preset(status_preset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_set(reg_set),
        .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
    );
    // Wait a number of falling edges
    task automatic step(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // One-cycle write; caller never issues two back to back
    task automatic wr(input logic [3:0] s, input logic [2:0] r, input logic [15:0] d);
        reg_wr = 1'h1;
        reg_set = s;
        reg_sel = r;
        reg_wdata = d;
        step(1);
        reg_wr = 1'h0;
    endtask
    // Read one register and compare with the expected word
    task automatic chk(input logic [3:0] s, input logic [2:0] r, input logic [15:0] e);
        reg_rd = 1'h1;
        reg_set = s;
        reg_sel = r;
        step(1);
        reg_rd = 1'h0;
        comparisons = comparisons + 1;
        if (reg_rvalid !== 1'h1 || reg_rdata !== e) begin
            err_count = err_count + 1;
            $display("mismatch set %0d sel %0d expected %h seen %h", s, r, e, reg_rdata);
        end
        step(1);
    endtask
    // Verdict and end of run
    task close_out;
        if (err_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        #20000;
        err_count = err_count + 1;
        close_out;
    end
    // Main sequence
    initial begin
        step(12);
        sys_rst = 1'h0;
        step(2);
        chk(4'h3, 3'h3, 16'h7fff);
        chk(4'h0, 3'h0, 16'h0000);
        nvm_failed = 1'h1;
        step(3);
        chk(4'h0, 3'h0, 16'h0008);
        chk(4'h0, 3'h0, 16'h0008);
        chk(4'h0, 3'h1, 16'h0008);
        chk(4'h0, 3'h1, 16'h0000);
        reg_rd = 1'h1;
        reg_sel = 3'h1;
        step(2);
        reg_rd = 1'h0;
        wr(4'h0, 3'h4, 16'hffff);
        chk(4'h0, 3'h4, 16'h7fff);
        nvm_failed = 1'h0;
        step(3);
        chk(4'h0, 3'h1, 16'h0008);
        wr(4'h0, 3'h0, 16'hffff);
        chk(4'h0, 3'h0, 16'h0000);
        chk(4'h9, 3'h0, 16'h0000);
        chk(4'h2, 3'h5, 16'h0000);
        for (int s = 1; s < 8; s++) begin
            wr(s[3:0], 3'h2, 16'hffff);
            chk(s[3:0], 3'h2, 16'h7fff);
        end
        cal_start = 1'h1;
        step(1);
        cal_start = 1'h0;
        step(3);
        chk(4'h2, 3'h0, 16'h0002);
        chk(4'h1, 3'h0, 16'h0001);
        meas_busy = 1'h1;
        mem_fetch_busy = 1'h1;
        trig_enter_wait = 1'h1;
        low_test_fail = 1'h1;
        high_test_fail = 1'h1;
        step(1);
        trig_enter_wait = 1'h0;
        low_test_fail = 1'h0;
        high_test_fail = 1'h0;
        step(3);
        chk(4'h4, 3'h0, 16'h0002);
        chk(4'h5, 3'h0, 16'h0002);
        chk(4'h6, 3'h0, 16'h0002);
        chk(4'h3, 3'h0, 16'h0002);
        chk(4'h7, 3'h0, 16'h0002);
        chk(4'h1, 3'h0, 16'h1c31);
        meas_done = 1'h1;
        meas_busy = 1'h0;
        low_test_en = 1'h1;
        cal_done = 1'h1;
        trig_enter_idle = 1'h1;
        mem_fetch_busy = 1'h0;
        step(1);
        meas_done = 1'h0;
        cal_done = 1'h0;
        trig_enter_idle = 1'h0;
        step(3);
        chk(4'h4, 3'h0, 16'h0000);
        chk(4'h3, 3'h0, 16'h0000);
        chk(4'h7, 3'h0, 16'h0002);
        chk(4'h2, 3'h0, 16'h0000);
        chk(4'h6, 3'h0, 16'h0000);
        chk(4'h5, 3'h0, 16'h0000);
        ques_pwr_summary = 1'h1;
        ques_cal_summary = 1'h1;
        selftest_fail = 1'h1;
        selftest_done = 1'h1;
        step(1);
        selftest_done = 1'h0;
        step(1);
        chk(4'h8, 3'h0, 16'h0308);
        ques_pwr_summary = 1'h0;
        selftest_fail = 1'h0;
        selftest_done = 1'h1;
        step(1);
        selftest_done = 1'h0;
        step(1);
        chk(4'h8, 3'h0, 16'h0100);
        wr(4'h0, 3'h2, 16'h0000);
        status_preset = 1'h1;
        step(1);
        status_preset = 1'h0;
        chk(4'h1, 3'h2, 16'h0000);
        chk(4'h8, 3'h2, 16'h0000);
        chk(4'h0, 3'h2, 16'h7fff);
        chk(4'h0, 3'h4, 16'h0000);
        chk(4'h7, 3'h0, 16'h0002);
        close_out;
    end
endmodule // tb_top
`default_nettype wire
